// File: ifm_regs.svh
// register offsets, reset values and bit positions of the interrupt flag and mask logic
// assumes an 8-bit register port with byte-wide offsets
//
// Overview of operation
// - upper mask register holds one mask bit per condition flag, same position
// - mask bit one blocks its flag from the interrupt, zero lets it drive
// - unmasking a set flag raises interrupt at once; masking drops it if none left
// - timer flags bit 7..0: general four, three, noise, meter, startup four..one
// - timer flag sets and stays set when its count goes from one to zero
// - writing zero clears a timer flag; writing one leaves it unchanged
// - a timer resting at zero never sets its cleared flag again
// - a flag set while unmasked drives the active-low interrupt active
// - clearing an unmasked timer flag releases interrupt if no other unmasked flag set
// - condition flags bits 3..0: sync, far-end high, far-end low, low noise ratio
// - writing zero to a condition flag whose condition is gone clears it at once
// - writing zero while condition holds keeps flag; it clears when condition ends
// - clearing an unmasked condition flag releases interrupt if none other set
// - sync condition: detector enabled and count strictly above lock threshold
// - far-end high condition: level meter strictly above high threshold
// - far-end low condition: level meter strictly below low threshold
// - noise alarm condition: noise meter strictly above its threshold
`ifndef IFM_REGS_SVH
`define IFM_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IFM_OFS_MASK_LOWER   8'h02
`define IFM_OFS_MASK_UPPER   8'h03
`define IFM_OFS_TIMER_FLAGS  8'h04
`define IFM_OFS_COND_FLAGS   8'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IFM_RST_MASK_LOWER   8'hFF
`define IFM_RST_MASK_UPPER   4'hF
`define IFM_RST_TIMER_FLAGS  8'h00
`define IFM_RST_COND_FLAGS   4'h0
`define IFM_RST_RDATA        8'h00
`define IFM_UNUSED_BITS      4'h0

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define IFM_TIMER_COUNT      8
`define IFM_COND_COUNT       4
`define IFM_COND_SYNC        3
`define IFM_COND_FAR_HIGH    2
`define IFM_COND_FAR_LOW     1
`define IFM_COND_LOW_NOISE   0

`endif

// File: ifm_pkg.sv
// types shared by the interrupt flag and mask logic
// assumes ifm_regs.svh supplies the layout constants
`include "ifm_regs.svh"

package ifm_pkg;

  typedef logic [7:0] ifm_byte_type;
  typedef logic [`IFM_TIMER_COUNT-1:0] ifm_timer_vec_type;
  typedef logic [`IFM_COND_COUNT-1:0] ifm_cond_vec_type;

endpackage

// File: ifm_flag_mask.sv
// interrupt flag and mask logic: timer and condition flags, masks, interrupt
// assumes timers, meters and thresholds come from logic on clk_in
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_flag_mask #(
  parameter int TIMER_W = 16,
  parameter int SYNC_W  = 8,
  parameter int METER_W = 16
) (
  input  wire logic                         clk_in,                      // 200 MHz clock
  input  wire logic                         rst_n_in,                    // async reset
  input  wire logic [7:0]                   reg_addr_in,                 // register offset
  input  wire logic [7:0]                   reg_wdata_in,                // write data
  input  wire logic                         reg_wr_in,                   // write strobe
  input  wire logic                         reg_rd_in,                   // read strobe
  output var  logic [7:0]                   reg_rdata_out,               // read data
  input  wire logic [8*TIMER_W-1:0]         timer_count_in,              // eight timer counts
  input  wire logic                         sync_enable_in,              // sync detector on
  input  wire logic [SYNC_W-1:0]            sync_count_in,               // equal-compare count
  input  wire logic [SYNC_W-1:0]            scrambler_lock_threshold_in, // sync threshold
  input  wire logic [METER_W-1:0]           far_end_level_in,            // far-end meter
  input  wire logic [METER_W-1:0]           far_end_high_threshold_in,   // high alarm level
  input  wire logic [METER_W-1:0]           far_end_low_threshold_in,    // low alarm level
  input  wire logic [METER_W-1:0]           noise_meter_in,              // noise alarm meter
  input  wire logic [METER_W-1:0]           noise_threshold_in,          // noise alarm level
  output var  logic                         irq_n_out                    // interrupt, low
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TIMER_W < 1) begin : g_bad_timer_w
    $error("timer width must be at least one bit");
  end
  if (SYNC_W < 1) begin : g_bad_sync_w
    $error("sync count width must be at least one bit");
  end
  if (METER_W < 1) begin : g_bad_meter_w
    $error("meter width must be at least one bit");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ifm_pkg::ifm_timer_vec_type timer_mask_reg;
  ifm_pkg::ifm_timer_vec_type timer_mask_next;
  ifm_pkg::ifm_cond_vec_type  cond_mask_reg;
  ifm_pkg::ifm_cond_vec_type  cond_mask_next;
  ifm_pkg::ifm_timer_vec_type timer_flag_reg;
  ifm_pkg::ifm_timer_vec_type timer_flag_next;
  ifm_pkg::ifm_cond_vec_type  cond_flag_reg;
  ifm_pkg::ifm_cond_vec_type  cond_flag_next;
  ifm_pkg::ifm_cond_vec_type  clear_pend_reg;
  ifm_pkg::ifm_cond_vec_type  clear_pend_next;
  ifm_pkg::ifm_timer_vec_type at_one_reg;
  ifm_pkg::ifm_timer_vec_type at_one_next;
  ifm_pkg::ifm_timer_vec_type at_zero;
  ifm_pkg::ifm_timer_vec_type timer_fall;
  ifm_pkg::ifm_cond_vec_type  cond_now;
  ifm_pkg::ifm_byte_type      rdata_next;
  logic                       irq_n_next;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire logic wr_mask_lower = reg_wr_in && (reg_addr_in == `IFM_OFS_MASK_LOWER);
  wire logic wr_mask_upper = reg_wr_in && (reg_addr_in == `IFM_OFS_MASK_UPPER);
  wire logic wr_timer_flag = reg_wr_in && (reg_addr_in == `IFM_OFS_TIMER_FLAGS);
  wire logic wr_cond_flag  = reg_wr_in && (reg_addr_in == `IFM_OFS_COND_FLAGS);
  wire logic rd_mask_lower = reg_rd_in && (reg_addr_in == `IFM_OFS_MASK_LOWER);
  wire logic rd_mask_upper = reg_rd_in && (reg_addr_in == `IFM_OFS_MASK_UPPER);
  wire logic rd_timer_flag = reg_rd_in && (reg_addr_in == `IFM_OFS_TIMER_FLAGS);
  wire logic rd_cond_flag  = reg_rd_in && (reg_addr_in == `IFM_OFS_COND_FLAGS);

  // a zero written to a flag bit is a clear request; ones do nothing
  wire ifm_pkg::ifm_timer_vec_type timer_clr =
    wr_timer_flag ? ~reg_wdata_in : `IFM_RST_TIMER_FLAGS;
  wire ifm_pkg::ifm_cond_vec_type cond_clr =
    wr_cond_flag ? ~reg_wdata_in[`IFM_COND_COUNT-1:0] : `IFM_RST_COND_FLAGS;

  // ----------------------------------------------------------------
  // timer edge detect
  // ----------------------------------------------------------------
  // bit order of timer_count_in follows the flag register, so slice i
  // is the timer whose flag sits in bit i
  for (genvar i = 0; i < `IFM_TIMER_COUNT; i++) begin : g_timer
    wire logic [TIMER_W-1:0] count = timer_count_in[i*TIMER_W +: TIMER_W];
    assign at_one_next[i] = (count == TIMER_W'(1));
    assign at_zero[i]     = (count == '0);
    // only a fresh one-to-zero step counts, a timer parked at zero does not
    assign timer_fall[i]  = at_one_reg[i] && at_zero[i];
  end

  // ----------------------------------------------------------------
  // condition sources
  // ----------------------------------------------------------------
  assign cond_now[`IFM_COND_SYNC] =
    sync_enable_in && (sync_count_in > scrambler_lock_threshold_in);
  assign cond_now[`IFM_COND_FAR_HIGH] =
    (far_end_level_in > far_end_high_threshold_in);
  assign cond_now[`IFM_COND_FAR_LOW] =
    (far_end_level_in < far_end_low_threshold_in);
  assign cond_now[`IFM_COND_LOW_NOISE] =
    (noise_meter_in > noise_threshold_in);

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  assign timer_mask_next = wr_mask_lower ? reg_wdata_in : timer_mask_reg;
  // upper nibble of the write is dropped
  assign cond_mask_next =
    wr_mask_upper ? reg_wdata_in[`IFM_COND_COUNT-1:0] : cond_mask_reg;

  // a new timer event wins over a clear in the same cycle
  assign timer_flag_next = timer_fall | (timer_flag_reg & ~timer_clr);

  // a clear made while the condition holds is parked until it goes away
  assign clear_pend_next = (clear_pend_reg | cond_clr) & cond_now;
  assign cond_flag_next =
    cond_now | (cond_flag_reg & ~cond_clr & ~clear_pend_reg);

  // computed from next values so the pin moves with the flags and masks
  assign irq_n_next =
    ~(|(timer_flag_next & ~timer_mask_next) |
      |(cond_flag_next & ~cond_mask_next));

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire ifm_pkg::ifm_byte_type rd_mask_upper_val =
    {`IFM_UNUSED_BITS, cond_mask_reg};
  wire ifm_pkg::ifm_byte_type rd_cond_flag_val =
    {`IFM_UNUSED_BITS, cond_flag_reg};

  // masked flags still read back, only the pin ignores them
  assign rdata_next =
    rd_mask_lower ? timer_mask_reg :
    rd_mask_upper ? rd_mask_upper_val :
    rd_timer_flag ? timer_flag_reg :
    rd_cond_flag  ? rd_cond_flag_val :
    `IFM_RST_RDATA;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_mask_reg <= `IFM_RST_MASK_LOWER;
      cond_mask_reg  <= `IFM_RST_MASK_UPPER;
    end else begin
      timer_mask_reg <= timer_mask_next;
      cond_mask_reg  <= cond_mask_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_flag_reg <= `IFM_RST_TIMER_FLAGS;
      at_one_reg     <= `IFM_RST_TIMER_FLAGS;
    end else begin
      timer_flag_reg <= timer_flag_next;
      at_one_reg     <= at_one_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond_flag_reg  <= `IFM_RST_COND_FLAGS;
      clear_pend_reg <= `IFM_RST_COND_FLAGS;
    end else begin
      cond_flag_reg  <= cond_flag_next;
      clear_pend_reg <= clear_pend_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= `IFM_RST_RDATA;
      irq_n_out     <= 1'b1;
    end else begin
      reg_rdata_out <= rdata_next;
      irq_n_out     <= irq_n_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_irq_gate_match: assert property (
    irq_n_out == ~(|(timer_flag_reg & ~timer_mask_reg) |
                   |(cond_flag_reg & ~cond_mask_reg)))
    else $error("interrupt pin disagrees with flags and masks");

  chk_timer_fall_sets: assert property (
    |timer_fall |=>
      ((timer_flag_reg & $past(timer_fall)) == $past(timer_fall)))
    else $error("timer one-to-zero step did not set its flag");

  chk_timer_no_reset: assert property (
    !(|timer_fall) |=> ((timer_flag_reg & ~$past(timer_flag_reg)) == '0))
    else $error("timer flag set without a one-to-zero step");

  chk_timer_zero_clr: assert property (
    wr_timer_flag |=>
      ((timer_flag_reg & ~$past(reg_wdata_in) & ~$past(timer_fall)) == '0))
    else $error("zero written to timer flag did not clear it");

  chk_timer_one_keeps: assert property (
    wr_timer_flag |=>
      ((timer_flag_reg & $past(reg_wdata_in)) ==
       (($past(timer_flag_reg) & $past(reg_wdata_in)) |
        ($past(timer_fall) & $past(reg_wdata_in)))))
    else $error("writing one changed a timer flag");

  chk_cond_clr_now: assert property (
    wr_cond_flag && !(|cond_now) |=>
      ((cond_flag_reg & ~$past(reg_wdata_in[`IFM_COND_COUNT-1:0])) == '0))
    else $error("condition flag not cleared with condition gone");

  chk_cond_held_set: assert property (
    |cond_now |=> ((cond_flag_reg & $past(cond_now)) == $past(cond_now)))
    else $error("condition flag not set while condition present");

  chk_cond_auto_clr: assert property (
    wr_cond_flag && cond_now[`IFM_COND_SYNC] &&
    !reg_wdata_in[`IFM_COND_SYNC] ##1
    !cond_now[`IFM_COND_SYNC] && !wr_cond_flag
    |=> !cond_flag_reg[`IFM_COND_SYNC])
    else $error("parked clear did not fire when condition ended");

  chk_mask_upper_wr: assert property (
    wr_mask_upper |=>
      (cond_mask_reg == $past(reg_wdata_in[`IFM_COND_COUNT-1:0])))
    else $error("upper mask write not stored");

  chk_upper_read_zero: assert property (
    rd_mask_upper || rd_cond_flag |=>
      (reg_rdata_out[7:`IFM_COND_COUNT] == `IFM_UNUSED_BITS))
    else $error("unused upper bits did not read zero");

  chk_unmask_raises: assert property (
    wr_mask_lower && |(timer_flag_next & ~reg_wdata_in) |=> !irq_n_out)
    else $error("unmasking a set flag did not raise interrupt");

  chk_clear_releases: assert property (
    wr_timer_flag && (reg_wdata_in == '0) && !(|timer_fall) &&
    !(|(cond_flag_next & ~cond_mask_next)) |=> irq_n_out)
    else $error("interrupt stayed active after last flag cleared");

  chk_read_latency: assert property (
    rd_timer_flag |=> (reg_rdata_out == $past(timer_flag_reg)))
    else $error("timer flag read returned wrong data");

  // ----------------------------------------------------------------
  // masks, stickiness and read paths
  // ----------------------------------------------------------------
  // masks change only on their own write, flags only by event or clear
  chk_mask_lower_wr: assert property (
    wr_mask_lower |=> (timer_mask_reg == $past(reg_wdata_in)))
    else $error("lower mask write not stored");

  chk_mask_lower_keep: assert property (
    !wr_mask_lower |=> $stable(timer_mask_reg))
    else $error("lower mask changed without a write");

  chk_mask_upper_keep: assert property (
    !wr_mask_upper |=> $stable(cond_mask_reg))
    else $error("upper mask changed without a write");

  chk_masked_quiet: assert property (
    ((timer_flag_next & ~timer_mask_next) == '0) &&
    ((cond_flag_next & ~cond_mask_next) == '0) |=> irq_n_out)
    else $error("interrupt active with every set flag masked");

  chk_timer_drives: assert property (
    |(timer_flag_next & ~timer_mask_next) |=> !irq_n_out)
    else $error("unmasked timer flag did not drive interrupt");

  chk_cond_drives: assert property (
    |(cond_flag_next & ~cond_mask_next) |=> !irq_n_out)
    else $error("unmasked condition flag did not drive interrupt");

  chk_mask_drops: assert property (
    wr_mask_upper &&
    ((cond_flag_next & ~reg_wdata_in[`IFM_COND_COUNT-1:0]) == '0) &&
    ((timer_flag_next & ~timer_mask_reg) == '0) |=> irq_n_out)
    else $error("masking the last set flag did not drop interrupt");

  chk_timer_sticky: assert property (
    !wr_timer_flag |=>
      ((timer_flag_reg & $past(timer_flag_reg)) == $past(timer_flag_reg)))
    else $error("timer flag dropped without a clear");

  chk_cond_sticky: assert property (
    !wr_cond_flag && !(|clear_pend_reg) |=>
      ((cond_flag_reg & $past(cond_flag_reg)) == $past(cond_flag_reg)))
    else $error("condition flag dropped without a clear");

  chk_cond_no_spur: assert property (
    !(|cond_now) |=> ((cond_flag_reg & ~$past(cond_flag_reg)) == '0))
    else $error("condition flag set with no condition");

  chk_pend_drops: assert property (
    !(|cond_now) |=> (clear_pend_reg == '0))
    else $error("parked clear outlived its condition");

  chk_cond_release: assert property (
    wr_cond_flag && (reg_wdata_in[`IFM_COND_COUNT-1:0] == '0) &&
    !(|cond_now) && ((timer_flag_next & ~timer_mask_next) == '0)
    |=> irq_n_out)
    else $error("interrupt stayed active after condition flags cleared");

  // sources are levels; a present condition must show up one edge later
  chk_sync_sets: assert property (
    sync_enable_in && (sync_count_in > scrambler_lock_threshold_in)
    |=> cond_flag_reg[`IFM_COND_SYNC])
    else $error("sync condition did not set its flag");

  chk_far_high_sets: assert property (
    (far_end_level_in > far_end_high_threshold_in)
    |=> cond_flag_reg[`IFM_COND_FAR_HIGH])
    else $error("far-end high condition did not set its flag");

  chk_far_low_sets: assert property (
    (far_end_level_in < far_end_low_threshold_in)
    |=> cond_flag_reg[`IFM_COND_FAR_LOW])
    else $error("far-end low condition did not set its flag");

  chk_noise_sets: assert property (
    (noise_meter_in > noise_threshold_in)
    |=> cond_flag_reg[`IFM_COND_LOW_NOISE])
    else $error("noise alarm condition did not set its flag");

  chk_read_mask_lower: assert property (
    rd_mask_lower |=> (reg_rdata_out == $past(timer_mask_reg)))
    else $error("lower mask read returned wrong data");

  chk_read_mask_upper: assert property (
    rd_mask_upper |=>
      (reg_rdata_out[`IFM_COND_COUNT-1:0] == $past(cond_mask_reg)))
    else $error("upper mask read returned wrong data");

  chk_read_cond: assert property (
    rd_cond_flag |=>
      (reg_rdata_out[`IFM_COND_COUNT-1:0] == $past(cond_flag_reg)))
    else $error("condition flag read returned wrong data");

  // read data stands one cycle only, so a stale byte cannot be re-read
  chk_rdata_idle: assert property (
    !reg_rd_in |=> (reg_rdata_out == `IFM_RST_RDATA))
    else $error("read data present without a read");

  chk_unmapped_read: assert property (
    reg_rd_in && !(rd_mask_lower || rd_mask_upper ||
                   rd_timer_flag || rd_cond_flag)
    |=> (reg_rdata_out == `IFM_RST_RDATA))
    else $error("unmapped read returned data");

endmodule // ifm_flag_mask

`default_nettype wire

// File: ifm_flag_mask_bench.sv
// self-checking bench for the interrupt flag and mask logic
// assumes one 200 MHz clock and the register map of ifm_regs.svh
`timescale 1ns/10ps
`default_nettype none
`include "ifm_regs.svh"

module ifm_flag_mask_bench;
  localparam logic [7:0] MSKL = `IFM_OFS_MASK_LOWER;
  localparam logic [7:0] MSKU = `IFM_OFS_MASK_UPPER;
  localparam logic [7:0] TFLG = `IFM_OFS_TIMER_FLAGS;
  localparam logic [7:0] CFLG = `IFM_OFS_COND_FLAGS;

  logic                  clk_in, rst_n_in, reg_wr_in, reg_rd_in, sync_enable_in, irq_n_out;
  ifm_pkg::ifm_byte_type reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [127:0]          timer_count_in;
  logic [7:0]            sync_count_in, scrambler_lock_threshold_in;
  logic [15:0]           far_end_level_in, far_end_high_threshold_in, far_end_low_threshold_in;
  logic [15:0]           noise_meter_in, noise_threshold_in;
  int                    bad_count, tests_run;

  ifm_flag_mask #(.TIMER_W(16), .SYNC_W(8), .METER_W(16)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .timer_count_in(timer_count_in),
    .sync_enable_in(sync_enable_in), .sync_count_in(sync_count_in),
    .scrambler_lock_threshold_in(scrambler_lock_threshold_in),
    .far_end_level_in(far_end_level_in), .far_end_high_threshold_in(far_end_high_threshold_in),
    .far_end_low_threshold_in(far_end_low_threshold_in), .noise_meter_in(noise_meter_in),
    .noise_threshold_in(noise_threshold_in), .irq_n_out(irq_n_out));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // read data is only valid in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, exp, what);
  endtask

  task automatic irq(input logic exp, input string what);
    check({7'h00, irq_n_out}, {7'h00, exp}, what);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // off values sit exactly on the threshold, except far-end low which returns to 16'h0200, so strictness is exercised too
  task automatic set_cond(input int k, input logic on);
    @(posedge clk_in);
    case (k)
      3: sync_count_in <= on ? 8'h11 : 8'h10;
      2: far_end_level_in <= on ? 16'h0201 : 16'h0200;
      1: far_end_level_in <= on ? 16'h007F : 16'h0200;
      default: noise_meter_in <= on ? 16'h0021 : 16'h0020;
    endcase
  endtask

  task automatic end_of_test;
    $display("TB: counts tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    bad_count = 0;
    tests_run = 0;
    timer_count_in = {8{16'h0005}};
    sync_enable_in = 1'b1;
    sync_count_in = 8'h10;
    scrambler_lock_threshold_in = 8'h10;
    far_end_level_in = 16'h0200;
    far_end_high_threshold_in = 16'h0200;
    far_end_low_threshold_in = 16'h0080;
    noise_meter_in = 16'h0020;
    noise_threshold_in = 16'h0020;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(MSKL, 8'hFF, "lower mask reset");
    rd(MSKU, 8'h0F, "upper mask reset");
    rd(TFLG, 8'h00, "timer flags reset");
    rd(CFLG, 8'h00, "equal values raise no condition");
    rd(8'h07, 8'h00, "unmapped read");
    irq(1'b1, "irq idle after reset");
    wr(MSKU, 8'hFF);
    rd(MSKU, 8'h0F, "upper mask unused bits");
    wr(CFLG, 8'hFF);
    rd(CFLG, 8'h00, "writing ones sets nothing");
    wr(MSKU, 8'h00);
    rd(MSKU, 8'h00, "upper mask cleared");
    @(posedge clk_in);
    sync_enable_in <= 1'b0;
    sync_count_in <= 8'h11;
    far_end_level_in <= 16'h0080;
    cycles(3);
    rd(CFLG, 8'h00, "disabled sync and equal low level");
    @(posedge clk_in);
    sync_enable_in <= 1'b1;
    sync_count_in <= 8'h10;
    far_end_level_in <= 16'h0200;
    $display("test done: reset and mask register");
    for (int k = 0; k < 4; k++) begin
      set_cond(k, 1'b1);
      cycles(2);
      rd(CFLG, 8'h01 << k, "condition flag set");
      irq(1'b0, "irq on unmasked condition");
      wr(CFLG, 8'h00);
      rd(CFLG, 8'h01 << k, "flag held while present");
      set_cond(k, 1'b0);
      cycles(2);
      rd(CFLG, 8'h00, "parked clear completes");
      irq(1'b1, "irq released");
    end
    set_cond(1, 1'b1);
    set_cond(1, 1'b0);
    cycles(2);
    rd(CFLG, 8'h02, "condition flag sticky");
    wr(MSKU, 8'h02);
    irq(1'b1, "masking set flag drops irq");
    wr(MSKU, 8'h00);
    irq(1'b0, "unmasking set flag raises irq");
    wr(CFLG, 8'h00);
    rd(CFLG, 8'h00, "clear with condition gone");
    irq(1'b1, "irq released after clear");
    $display("test done: condition flags");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      timer_count_in[16*i +: 16] <= 16'h0001;
      @(posedge clk_in);
      timer_count_in[16*i +: 16] <= 16'h0000;
      cycles(2);
      rd(TFLG, 8'hFF >> (7 - i), "timer flag order");
      irq(1'b1, "masked timer flags stay quiet");
    end
    wr(MSKL, 8'h00);
    irq(1'b0, "unmask set timer flags");
    wr(TFLG, 8'h7F);
    rd(TFLG, 8'h7F, "write zero clears one flag only");
    wr(MSKL, 8'h7F);
    irq(1'b1, "mask remaining timer flags");
    wr(MSKL, 8'h00);
    irq(1'b0, "remaining flags drive irq");
    wr(TFLG, 8'h00);
    irq(1'b1, "all timer flags cleared");
    cycles(4);
    rd(TFLG, 8'h00, "timer at zero does not reassert");
    $display("test done: timer flags");
    end_of_test();
  end
endmodule // ifm_flag_mask_bench
`default_nettype wire
